// File: core/ring_fairness_msg_framer.sv
// fairness message framer: periodic single- and multi-choke message generation,
// received message validation, choke rate hold and client delivery
// assumes the rate computation and congestion detection drive the rate inputs,
// and that the mac takes a message on tx_valid && tx_ready
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ring_fairness_msg_framer
	import ring_fairness_pkg::*;
#(
	parameter int MAX_FRAME_CYCLES = 16
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	// congestion state and rates from the rate computation
	input wire logic own_span_congested,
	input wire logic downstream_congested,
	input wire logic [15:0] normalized_local_share,
	input wire logic [15:0] norm_fw_rate_congested,
	// received fairness messages
	input wire logic rx_valid,
	input wire logic [2:0] rx_kind,
	input wire logic [15:0] rx_rate,
	input wire logic [47:0] rx_sa,
	input wire logic [7:0] rx_ttl,
	input wire logic rx_ri,
	// outgoing fairness messages
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_ring_ctl,
	output logic [2:0] tx_kind,
	output logic [12:0] tx_reserved,
	output logic [15:0] tx_rate,
	output logic [47:0] tx_sa,
	output logic [7:0] tx_ttl,
	// toward the data path shapers
	output logic [15:0] allowed_rate_at_choke,
	output logic [8:0] hop_distance,
	// toward the client
	output logic client_valid,
	output logic [15:0] client_rate,
	output logic [47:0] client_sa
);

	typedef enum logic [0:0] {TX_IDLE, TX_HOLD} tx_state_t;

	typedef struct packed {
		tx_state_t st;
		logic sc_pending;
		logic mc_pending;
		logic enable;
		logic ringlet;
		logic wrap;
		logic [PERIOD_W-1:0] advert_period;
		logic [PERIOD_W-1:0] aging_period;
		logic [47:0] local_addr;
		logic [15:0] rcvd_rate;
		logic [47:0] rcvd_sa;
		logic [7:0] rcvd_ttl;
		logic rcvd_ri;
		logic [15:0] allowed_rate;
		logic [8:0] hop_dist;
		logic client_valid;
		logic [15:0] client_rate;
		logic [47:0] client_sa;
		logic [7:0] tx_hdr;
		logic [2:0] tx_kind;
		logic [15:0] tx_rate;
		logic [47:0] tx_sa;
		logic [7:0] tx_ttl;
		logic [15:0] self_drops;
		logic [15:0] rsvd_drops;
		logic [15:0] tx_count;
		logic [DATA_W-1:0] rdata;
	} state_t;

	state_t s_reg;
	state_t s_next;

	logic sc_tick;
	logic mc_tick;
	logic row_local;
	logic row_forward;
	logic [15:0] sc_rate;
	logic [47:0] sc_sa;
	logic [7:0] sc_ttl;
	logic sc_ri;
	logic [15:0] mc_rate;
	logic [7:0] hdr_sc;
	logic [7:0] hdr_local;
	logic rx_known;
	logic rx_self;
	logic period_warn;

	// advertisement tick, then every tenth of those for multi-choke
	period_divider #(.WIDTH(PERIOD_W)) u_advert_div
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.en(s_reg.enable),
		.period(s_reg.advert_period),
		.tick(sc_tick)
	);

	period_divider #(.WIDTH(4)) u_multi_div
	(
		.mclk(mclk),
		.reset_n(reset_n),
		.en(sc_tick),
		.period(MULTI_CHOKE_RATIO),
		.tick(mc_tick)
	);

	// headers for the two possible origins of a message
	ring_header_build u_hdr_sc
	(
		.ringlet_id_bit(sc_ri),
		.ring_header_ctl(hdr_sc)
	);

	ring_header_build u_hdr_local
	(
		.ringlet_id_bit(s_reg.ringlet),
		.ring_header_ctl(hdr_local)
	);

	// single-choke choice; an equal-rate tie with both congested advertises the local share
	assign row_local = own_span_congested && (!downstream_congested || normalized_local_share <= s_reg.rcvd_rate);
	assign row_forward = !row_local && downstream_congested && (s_reg.rcvd_rate < norm_fw_rate_congested);
	assign sc_rate = row_local ? normalized_local_share : (row_forward ? s_reg.rcvd_rate : FULL_RATE);
	assign sc_sa = row_forward ? s_reg.rcvd_sa : s_reg.local_addr;
	assign sc_ttl = row_forward ? s_reg.rcvd_ttl : MAX_HOP_LIMIT;
	assign sc_ri = row_forward ? s_reg.rcvd_ri : s_reg.ringlet;
	assign mc_rate = own_span_congested ? normalized_local_share : FULL_RATE;

	// receive classification
	assign rx_known = (rx_kind == KIND_SINGLE_CHOKE) || (rx_kind == KIND_MULTI_CHOKE);
	assign rx_self = (rx_sa == s_reg.local_addr) && (s_reg.wrap || rx_ri == s_reg.ringlet);

	// period outside the recommended range is only flagged, never corrected
	assign period_warn = (s_reg.advert_period < PERIOD_W'(MAX_FRAME_CYCLES))
		|| (s_reg.advert_period > s_reg.aging_period);

	// next state of the whole block
	always_comb
	begin
		logic pend_sc;
		logic pend_mc;
		logic can_load;
		can_load = 1'b0;
		s_next = s_reg;
		pend_sc = s_reg.sc_pending | sc_tick;
		pend_mc = s_reg.mc_pending | mc_tick;
		s_next.sc_pending = pend_sc;
		s_next.mc_pending = pend_mc;
		s_next.client_valid = 1'b0;
		s_next.rdata = '0;
		case (s_reg.st)
			TX_IDLE: can_load = 1'b1;
			TX_HOLD: can_load = tx_ready;
			default: can_load = 1'b1;
		endcase
		// a new tick either launches now or stays pending; one landing on a stalled pending tick of its kind merges with it
		if (can_load)
		begin
			if (s_reg.st == TX_HOLD)
				s_next.tx_count = s_reg.tx_count + 16'h0001;
			if (pend_sc)
			begin
				// set wins: a tick landing on the launch of an older one stays pending
				s_next.sc_pending = s_reg.sc_pending & sc_tick;
				s_next.st = TX_HOLD;
				s_next.tx_kind = KIND_SINGLE_CHOKE;
				s_next.tx_rate = sc_rate;
				s_next.tx_sa = sc_sa;
				s_next.tx_ttl = sc_ttl;
				s_next.tx_hdr = hdr_sc;
			end
			else if (pend_mc)
			begin
				s_next.mc_pending = s_reg.mc_pending & mc_tick;
				s_next.st = TX_HOLD;
				s_next.tx_kind = KIND_MULTI_CHOKE;
				s_next.tx_rate = mc_rate;
				s_next.tx_sa = s_reg.local_addr;
				s_next.tx_ttl = MAX_HOP_LIMIT;
				s_next.tx_hdr = hdr_local;
			end
			else
				s_next.st = TX_IDLE;
		end
		// received messages; the reserved field is never looked at
		if (rx_valid)
		begin
			if (!rx_known)
				s_next.rsvd_drops = s_reg.rsvd_drops + 16'h0001;
			else if (rx_self)
				s_next.self_drops = s_reg.self_drops + 16'h0001;
			else if (rx_kind == KIND_SINGLE_CHOKE)
			begin
				s_next.rcvd_rate = rx_rate;
				s_next.rcvd_sa = rx_sa;
				s_next.rcvd_ttl = rx_ttl;
				s_next.rcvd_ri = rx_ri;
				s_next.allowed_rate = rx_rate;
				s_next.hop_dist = HOP_BASE - {1'b0, rx_ttl};
			end
			else
			begin
				s_next.client_valid = 1'b1;
				s_next.client_rate = rx_rate;
				s_next.client_sa = rx_sa;
			end
		end
		// register writes
		if (reg_wr)
		begin
			case (reg_addr)
				CTRL_ADDR:
				begin
					s_next.enable = reg_wdata[CTRL_ENABLE_BIT];
					s_next.ringlet = reg_wdata[CTRL_RINGLET_BIT];
					s_next.wrap = reg_wdata[CTRL_WRAP_BIT];
				end
				ADVERT_ADDR: s_next.advert_period = reg_wdata[PERIOD_W-1:0];
				AGING_ADDR: s_next.aging_period = reg_wdata[PERIOD_W-1:0];
				ADDR_LO_ADDR: s_next.local_addr[31:0] = reg_wdata;
				ADDR_HI_ADDR: s_next.local_addr[47:32] = reg_wdata[15:0];
				default: ;
			endcase
		end
		// register reads, answered in the next cycle; unmapped reads give zero
		if (reg_rd)
		begin
			case (reg_addr)
				CTRL_ADDR: s_next.rdata = {29'h00000000, s_reg.wrap, s_reg.ringlet, s_reg.enable};
				ADVERT_ADDR: s_next.rdata = {8'h00, s_reg.advert_period};
				AGING_ADDR: s_next.rdata = {8'h00, s_reg.aging_period};
				ADDR_LO_ADDR: s_next.rdata = s_reg.local_addr[31:0];
				ADDR_HI_ADDR: s_next.rdata = {16'h0000, s_reg.local_addr[47:32]};
				STATUS_ADDR: s_next.rdata = {6'h00, period_warn, s_reg.hop_dist, s_reg.allowed_rate};
				DROPS_ADDR: s_next.rdata = {s_reg.rsvd_drops, s_reg.self_drops};
				TX_COUNT_ADDR: s_next.rdata = {16'h0000, s_reg.tx_count};
				default: s_next.rdata = '0;
			endcase
		end
	end

	// state register
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			s_reg <= '0;
			s_reg.st <= TX_IDLE;
			s_reg.advert_period <= ADVERT_PERIOD_RESET;
			s_reg.aging_period <= AGING_PERIOD_RESET;
			s_reg.local_addr <= LOCAL_ADDR_RESET;
			s_reg.rcvd_rate <= FULL_RATE;
			s_reg.allowed_rate <= FULL_RATE;
			s_reg.rcvd_ttl <= MAX_HOP_LIMIT;
			s_reg.tx_ttl <= MAX_HOP_LIMIT;
		end
		else
			s_reg <= s_next;
	end

	// outputs
	assign tx_valid = (s_reg.st == TX_HOLD);
	assign tx_ring_ctl = s_reg.tx_hdr;
	assign tx_kind = s_reg.tx_kind;
	assign tx_reserved = RESERVED_ZERO;
	assign tx_rate = s_reg.tx_rate;
	assign tx_sa = s_reg.tx_sa;
	assign tx_ttl = s_reg.tx_ttl;
	assign allowed_rate_at_choke = s_reg.allowed_rate;
	assign hop_distance = s_reg.hop_dist;
	assign client_valid = s_reg.client_valid;
	assign client_rate = s_reg.client_rate;
	assign client_sa = s_reg.client_sa;
	assign reg_rdata = s_reg.rdata;

	// checks on what the block drives
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!reset_n);

	chk_header_parity: assert property (tx_valid |-> ^tx_ring_ctl)
		else $error("outgoing header parity is even");
	chk_header_fixed: assert property (tx_valid |-> tx_ring_ctl[7:2] == 6'h2D)
		else $error("outgoing header fixed fields wrong");
	chk_kind_legal: assert property (tx_valid |-> tx_kind <= KIND_MULTI_CHOKE)
		else $error("reserved message kind sent");
	chk_local_hop_limit: assert property (tx_valid && tx_sa == s_reg.local_addr |-> tx_ttl == 8'hFF)
		else $error("local source without hop limit 255");
	chk_multi_origin: assert property (tx_valid && tx_kind == KIND_MULTI_CHOKE
		|-> tx_sa == s_reg.local_addr && tx_ring_ctl[HDR_RI_POS] == s_reg.ringlet)
		else $error("multi-choke message not locally sourced");
	chk_choke_hold: assert property (!$stable(allowed_rate_at_choke)
		|-> $past(rx_valid) && $past(rx_kind) == KIND_SINGLE_CHOKE)
		else $error("choke rate changed without a single-choke message");
	chk_self_ignored: assert property (rx_valid && rx_sa == s_reg.local_addr
		&& (rx_ri == s_reg.ringlet || s_reg.wrap) && !reg_wr
		|=> $stable(allowed_rate_at_choke) && !client_valid)
		else $error("self-originated message was used");
	chk_hop_distance: assert property (rx_valid && !rx_self && rx_kind == KIND_SINGLE_CHOKE
		|=> hop_distance == 9'h100 - {1'b0, $past(rx_ttl)})
		else $error("hop distance not 256 minus hop limit");
	chk_multi_deliver: assert property (rx_valid && !rx_self && rx_kind == KIND_MULTI_CHOKE
		|=> client_valid && client_rate == $past(rx_rate) && client_sa == $past(rx_sa))
		else $error("multi-choke rate not delivered to client");
	chk_reserved_drop: assert property (rx_valid && rx_kind > KIND_MULTI_CHOKE
		|=> !client_valid && $stable(allowed_rate_at_choke) && $stable(hop_distance))
		else $error("reserved kind changed fairness state");
	chk_sc_launch: assert property (sc_tick && !tx_valid |=> tx_valid && tx_kind == KIND_SINGLE_CHOKE)
		else $error("single-choke message not launched on tick");

	cov_single_sent: cover property (tx_valid && tx_ready && tx_kind == KIND_SINGLE_CHOKE);
	cov_multi_sent: cover property (tx_valid && tx_ready && tx_kind == KIND_MULTI_CHOKE);
	cov_forwarded: cover property (tx_valid && tx_ready && tx_sa != s_reg.local_addr);
	cov_self_drop: cover property (rx_valid && rx_known && rx_self);

endmodule
`default_nettype wire

// File: core/ring_fairness_pkg.sv
// constants shared by the fairness message framer and its helpers
// assumes one 25 MHz station clock and a plain address/strobe register port
package ring_fairness_pkg;

	// register port shape
	localparam int DATA_W = 32;
	localparam int ADDR_W = 8;
	localparam int PERIOD_W = 24;

	// register byte addresses
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] ADVERT_ADDR = 8'h04;
	localparam logic [7:0] AGING_ADDR = 8'h08;
	localparam logic [7:0] ADDR_LO_ADDR = 8'h0C;
	localparam logic [7:0] ADDR_HI_ADDR = 8'h10;
	localparam logic [7:0] STATUS_ADDR = 8'h14;
	localparam logic [7:0] DROPS_ADDR = 8'h18;
	localparam logic [7:0] TX_COUNT_ADDR = 8'h1C;

	// control register bit positions
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int CTRL_RINGLET_BIT = 1;
	localparam int CTRL_WRAP_BIT = 2;

	// reset values
	localparam logic [PERIOD_W-1:0] ADVERT_PERIOD_RESET = 24'h000400;
	localparam logic [PERIOD_W-1:0] AGING_PERIOD_RESET = 24'h004000;
	localparam logic [47:0] LOCAL_ADDR_RESET = 48'h000000000000;

	// message timing: multi-choke every ten advertisement periods
	localparam logic [3:0] MULTI_CHOKE_RATIO = 4'hA;

	// message contents
	localparam logic [2:0] KIND_SINGLE_CHOKE = 3'h0;
	localparam logic [2:0] KIND_MULTI_CHOKE = 3'h1;
	localparam logic [15:0] FULL_RATE = 16'hFFFF;
	localparam logic [12:0] RESERVED_ZERO = 13'h0000;
	localparam logic [7:0] MAX_HOP_LIMIT = 8'hFF;
	localparam logic [8:0] HOP_BASE = 9'h100;

	// ring header control byte: values and bit positions
	localparam logic [1:0] FRAME_KIND_FAIRNESS = 2'h2;
	localparam logic [1:0] SERVICE_CLASS_A0 = 2'h3;
	localparam logic FAIRNESS_ELIGIBLE_VAL = 1'h0;
	localparam logic WRAP_ELIGIBLE_VAL = 1'h1;
	localparam int HDR_PARITY_POS = 0;
	localparam int HDR_RI_POS = 1;
	localparam int HDR_WE_POS = 2;
	localparam int HDR_FE_POS = 3;
	localparam int HDR_SC_LSB = 4;
	localparam int HDR_FK_LSB = 6;

endpackage

// File: core/period_divider.sv
// counts enable pulses and issues one tick every 'period' of them
// assumes period is stable while counting; a period of zero acts as one
`timescale 1ns/1ps
`default_nettype none
module period_divider
#(
	parameter int WIDTH = 24
)
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// count control
	input wire logic en,
	input wire logic [WIDTH-1:0] period,
	// one-cycle tick
	output logic tick
);

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
	} div_state_t;

	div_state_t div_reg;
	div_state_t div_next;

	// tick on the enable that finds the count at zero, so the first tick is immediate
	assign tick = en && (div_reg.cnt == '0);

	// reload on tick, else count down
	always_comb
	begin
		div_next = div_reg;
		if (tick)
			div_next.cnt = (period == '0) ? '0 : period - WIDTH'(1);
		else if (en)
			div_next.cnt = div_reg.cnt - WIDTH'(1);
	end

	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
			div_reg <= '0;
		else
			div_reg <= div_next;
	end

endmodule
`default_nettype wire

// File: core/ring_header_build.sv
// builds the ring header control byte of an outgoing fairness message
// purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module ring_header_build
	import ring_fairness_pkg::*;
(
	// ringlet the message belongs to
	input wire logic ringlet_id_bit,
	// finished header byte
	output logic [7:0] ring_header_ctl
);

	logic [7:0] body;

	// fixed fields, ringlet bit, then parity that makes the byte odd
	always_comb
	begin
		body = 8'h00;
		body[HDR_FK_LSB +: 2] = FRAME_KIND_FAIRNESS;
		body[HDR_SC_LSB +: 2] = SERVICE_CLASS_A0;
		body[HDR_FE_POS] = FAIRNESS_ELIGIBLE_VAL;
		body[HDR_WE_POS] = WRAP_ELIGIBLE_VAL;
		body[HDR_RI_POS] = ringlet_id_bit;
		ring_header_ctl = body;
		ring_header_ctl[HDR_PARITY_POS] = ~(^body);
	end

endmodule
`default_nettype wire

// File: test/peer_mac_model.sv
// peer mac model: takes framer messages and feeds it received fairness messages
// assumes the framer's clock; the bench calls send_msg and reads the logs
`timescale 1ns/1ps
`default_nettype none
module peer_mac_model
(
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// pace: a slow peer takes a message every other cycle only
	input wire logic slow,
	// messages from the framer
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_ring_ctl,
	input wire logic [2:0] tx_kind,
	input wire logic [12:0] tx_reserved,
	input wire logic [15:0] tx_rate,
	input wire logic [47:0] tx_sa,
	input wire logic [7:0] tx_ttl,
	// messages toward the framer
	output logic rx_valid,
	output logic [2:0] rx_kind,
	output logic [15:0] rx_rate,
	output logic [47:0] rx_sa,
	output logic [7:0] rx_ttl,
	output logic rx_ri
);
	logic [95:0] msg_log[$];
	int cyc_log[$];
	int cyc;
	int n_unstable = 0;
	logic stalled;
	logic [95:0] held;
	logic [95:0] cur;

	assign cur = {tx_ring_ctl, tx_kind, tx_reserved, tx_rate, tx_sa, tx_ttl};

	// idle receive lines
	initial
	begin
		rx_valid = 1'b0;
		{rx_kind, rx_rate, rx_sa, rx_ttl, rx_ri} = '0;
	end

	// take messages, log them with their cycle, and watch fields held while stalled
	always @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_ready <= 1'b1;
			cyc <= 0;
			stalled <= 1'b0;
		end
		else
		begin
			cyc <= cyc + 1;
			tx_ready <= slow ? ~tx_ready : 1'b1;
			stalled <= tx_valid && !tx_ready;
			held <= cur;
			if (stalled && cur !== held)
				n_unstable++;
			if (tx_valid && tx_ready)
			begin
				msg_log.push_back(cur);
				cyc_log.push_back(cyc);
			end
		end
	end

	// one-cycle message; fields inverted afterwards so stale values never pass as fresh
	task automatic send_msg(input logic [2:0] kind, input logic [15:0] rate, input logic [47:0] sa,
		input logic [7:0] ttl, input logic ri);
		@(posedge mclk);
		rx_valid <= 1'b1;
		rx_kind <= kind;
		rx_rate <= rate;
		rx_sa <= sa;
		rx_ttl <= ttl;
		rx_ri <= ri;
		@(posedge mclk);
		rx_valid <= 1'b0;
		{rx_kind, rx_rate, rx_sa, rx_ttl, rx_ri} <= ~{kind, rate, sa, ttl, ri};
	endtask
endmodule
`default_nettype wire

// File: test/ring_fairness_msg_framer_tb.sv
// testbench for the fairness message framer: register, receive and transmit sequences
// assumes the peer mac model on the message ports; advert period shortened to 8 cycles
`timescale 1ns/1ps
`default_nettype none
module ring_fairness_msg_framer_tb
	import ring_fairness_pkg::*;
;
	localparam logic [47:0] LOCAL = 48'h456789ABCDEF;
	localparam logic [47:0] PEER_A = 48'h0A0000000001;
	localparam logic [47:0] PEER_B = 48'h0B0000000002;
	logic mclk, reset_n, reg_wr, reg_rd, own_span_congested, downstream_congested, slow;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic [15:0] normalized_local_share, norm_fw_rate_congested, rx_rate, tx_rate;
	logic [15:0] allowed_rate_at_choke, client_rate;
	logic rx_valid, rx_ri, tx_valid, tx_ready, client_valid;
	logic [2:0] rx_kind, tx_kind;
	logic [47:0] rx_sa, tx_sa, client_sa;
	logic [7:0] rx_ttl, tx_ttl, tx_ring_ctl;
	logic [12:0] tx_reserved;
	logic [8:0] hop_distance;
	int n_mismatch = 0;
	int cmp_count = 0;

	ring_fairness_msg_framer i_dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.own_span_congested(own_span_congested), .downstream_congested(downstream_congested),
		.normalized_local_share(normalized_local_share), .norm_fw_rate_congested(norm_fw_rate_congested),
		.rx_valid(rx_valid), .rx_kind(rx_kind), .rx_rate(rx_rate), .rx_sa(rx_sa), .rx_ttl(rx_ttl),
		.rx_ri(rx_ri), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_ring_ctl(tx_ring_ctl),
		.tx_kind(tx_kind), .tx_reserved(tx_reserved), .tx_rate(tx_rate), .tx_sa(tx_sa), .tx_ttl(tx_ttl),
		.allowed_rate_at_choke(allowed_rate_at_choke), .hop_distance(hop_distance),
		.client_valid(client_valid), .client_rate(client_rate), .client_sa(client_sa));

	peer_mac_model i_peer (.mclk(mclk), .reset_n(reset_n), .slow(slow), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_ring_ctl(tx_ring_ctl), .tx_kind(tx_kind), .tx_reserved(tx_reserved),
		.tx_rate(tx_rate), .tx_sa(tx_sa), .tx_ttl(tx_ttl), .rx_valid(rx_valid), .rx_kind(rx_kind),
		.rx_rate(rx_rate), .rx_sa(rx_sa), .rx_ttl(rx_ttl), .rx_ri(rx_ri));

	// value comparison
	task automatic check(input string name, input logic [95:0] exp, input logic [95:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// expected message: header byte with odd parity, then kind, zero reserved, rate, source, hop limit
	function automatic logic [95:0] msg(input logic ri, input logic [2:0] kind, input logic [15:0] rate,
		input logic [47:0] sa, input logic [7:0] ttl);
		logic [6:0] u;
		u = {2'h2, 2'h3, 1'h0, 1'h1, ri};
		return {u, ~^u, kind, 13'h0000, rate, sa, ttl};
	endfunction

	// register port cycles
	task automatic reg_write(input logic [7:0] addr, input logic [31:0] data);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_check(input string name, input logic [7:0] addr, input logic [31:0] exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= addr;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		check(name, exp, reg_rdata);
	endtask

	// one received message and the state it must leave behind
	task automatic rx_case(input logic [2:0] kind, input logic [15:0] rate, input logic [47:0] sa,
		input logic [7:0] ttl, input logic ri, input logic [15:0] exp_rate, input logic [8:0] exp_hop);
		i_peer.send_msg(kind, rate, sa, ttl, ri);
		#1;
		check("allowed_rate", exp_rate, allowed_rate_at_choke);
		check("hop_distance", exp_hop, hop_distance);
		check("client_valid", kind == 3'h1, client_valid);
	endtask

	// bounded wait for the peer to have taken n messages
	task automatic wait_log(input int n);
		repeat (400)
			if (i_peer.msg_log.size() < n)
				@(posedge mclk);
	endtask

	task automatic finish_test();
		if (n_mismatch == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// whole run is a few hundred cycles; 5000 cycles means a hang
	initial
	begin
		#200000;
		n_mismatch++;
		finish_test();
	end

	// main sequence
	initial
	begin
		{reset_n, reg_wr, reg_rd, downstream_congested, slow} = '0;
		reg_addr = 8'h00;
		reg_wdata = 32'h00000000;
		own_span_congested = 1'b1;
		normalized_local_share = 16'h1234;
		norm_fw_rate_congested = 16'hFFFF;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		reg_check("advert", ADVERT_ADDR, 32'h00000400);
		reg_check("aging", AGING_ADDR, 32'h00004000);
		reg_check("status", STATUS_ADDR, 32'h0000FFFF);
		reg_check("unmapped", 8'h20, 32'h00000000);
		reg_write(ADDR_LO_ADDR, 32'h89ABCDEF);
		reg_write(ADDR_HI_ADDR, 32'h00004567);
		reg_check("addr_hi", ADDR_HI_ADDR, 32'h00004567);
		reg_write(ADVERT_ADDR, 32'h00000008);
		reg_write(CTRL_ADDR, 32'h00000002);
		rx_case(3'h0, 16'h4321, PEER_A, 8'hF0, 1'h1, 16'h4321, 9'h010);
		rx_case(3'h0, 16'h1111, LOCAL, 8'h80, 1'h1, 16'h4321, 9'h010);
		rx_case(3'h0, 16'h2222, LOCAL, 8'h01, 1'h0, 16'h2222, 9'h0FF);
		reg_write(CTRL_ADDR, 32'h00000006);
		reg_check("ctrl", CTRL_ADDR, 32'h00000006);
		rx_case(3'h0, 16'h3333, LOCAL, 8'h40, 1'h0, 16'h2222, 9'h0FF);
		for (int k = 2; k < 8; k++)
			rx_case(3'(k), 16'h7777, PEER_A, 8'h20, 1'h1, 16'h2222, 9'h0FF);
		rx_case(3'h1, 16'h5555, PEER_A, 8'h10, 1'h1, 16'h2222, 9'h0FF);
		check("client", {16'h5555, PEER_A}, {client_rate, client_sa});
		rx_case(3'h0, 16'h0AAA, PEER_B, 8'h33, 1'h0, 16'h0AAA, 9'h0CD);
		reg_check("drops", DROPS_ADDR, 32'h00060002);
		reg_check("status", STATUS_ADDR, 32'h02CD0AAA);
		// transmit: congested, then idle, then forwarding the choke rate
		reg_write(CTRL_ADDR, 32'h00000003);
		wait_log(2);
		own_span_congested <= 1'b0;
		wait_log(13);
		downstream_congested <= 1'b1;
		wait_log(14);
		check("single_congested", msg(1'h1, 3'h0, 16'h1234, LOCAL, 8'hFF), i_peer.msg_log[0]);
		check("multi_congested", msg(1'h1, 3'h1, 16'h1234, LOCAL, 8'hFF), i_peer.msg_log[1]);
		for (int k = 2; k < 12; k++)
			check("single_idle", msg(1'h1, 3'h0, 16'hFFFF, LOCAL, 8'hFF), i_peer.msg_log[k]);
		check("multi_idle", msg(1'h1, 3'h1, 16'hFFFF, LOCAL, 8'hFF), i_peer.msg_log[12]);
		check("forward", msg(1'h0, 3'h0, 16'h0AAA, PEER_B, 8'h33), i_peer.msg_log[13]);
		check("single_gap", 96'h8, 96'(i_peer.cyc_log[2] - i_peer.cyc_log[0]));
		check("single_span", 96'h50, 96'(i_peer.cyc_log[11] - i_peer.cyc_log[0]));
		check("multi_span", 96'h50, 96'(i_peer.cyc_log[12] - i_peer.cyc_log[1]));
		// slow peer: fields must stand while stalled
		slow <= 1'b1;
		norm_fw_rate_congested <= 16'h0AAA;
		wait_log(17);
		check("choke_not_upstream", msg(1'h1, 3'h0, 16'hFFFF, LOCAL, 8'hFF), i_peer.msg_log[14]);
		reg_write(CTRL_ADDR, 32'h00000002);
		repeat (20) @(posedge mclk);
		check("stall_hold", 96'h0, 96'(i_peer.n_unstable));
		reg_check("tx_count", TX_COUNT_ADDR, 32'(i_peer.msg_log.size()));
		finish_test();
	end
endmodule
`default_nettype wire
